// ---- logic/dpr_pkg.sv ----
// Constants and types shared by the serial-bus wiper target.
// Assumes a single system clock; the bus lines arrive as raw pins.
//
// Summary of operation
// - Any Start resets the interface state machine
// - Released acknowledge slot on read ends the read
// - Recovery leaves wipers and pointer untouched
// - After Stop, ignore bus until next Start
// - General call accepts increment, decrement, write
// - Invalid command: release line, wait for Start
// - Pointer survives Start/Stop, resets to zero
package dpr_pkg;

   // Own target address on the bus (value chosen for this block)
   localparam logic [6:0] DPR_DEV_ADDR = 7'h2E;
   // General call address
   localparam logic [6:0] DPR_GC_ADDR = 7'h00;
   // Wiper reset value is mid-scale, full scale is the top step
   localparam logic [8:0] DPR_WIPER_RESET = 9'h080;
   localparam logic [8:0] DPR_WIPER_FULL = 9'h100;
   localparam logic [8:0] DPR_WIPER_ZERO = 9'h000;
   // Memory address pointer after reset
   localparam logic [3:0] DPR_PTR_RESET = 4'h0;
   // Highest valid memory address (volatile wipers 0 and 1)
   localparam logic [3:0] DPR_PTR_MAX = 4'h1;
   // Data bits in one byte, counted before the acknowledge slot
   localparam logic [3:0] DPR_BYTE_BITS = 4'h8;
   // Command byte field positions
   localparam int DPR_CMD_ADDR_LSB = 4;
   localparam int DPR_CMD_OP_LSB = 2;
   localparam int DPR_CMD_D8_POS = 0;

   // Command operation codes
   typedef enum logic [1:0] {
      DPR_OP_WRITE = 2'b00,
      DPR_OP_INC = 2'b01,
      DPR_OP_DEC = 2'b10,
      DPR_OP_READ = 2'b11
   } dpr_op_t;

   // Interface state machine
   typedef enum logic [3:0] {
      DPR_ST_IDLE,
      DPR_ST_ADDR,
      DPR_ST_CMD,
      DPR_ST_DATA,
      DPR_ST_ACK,
      DPR_ST_RD,
      DPR_ST_RD_ACK,
      DPR_ST_IGNORE
   } dpr_state_t;

endpackage

// ---- logic/dpr_line_sync.sv ----
// Bus line synchroniser and condition detector.
// Assumes the clock line and data line are asynchronous pins.
module dpr_line_sync (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Raw bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   // Detected events, one cycle each
   output logic scl_rise,
   output logic scl_fall,
   output logic start_det,
   output logic stop_det,
   // Synchronised data level
   output logic sda_s
);

   // Three stages per line: two to synchronise, one to find edges
   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] s3;
   } dpr_sync_t;

   dpr_sync_t sync_q, sync_d;
   logic [1:0] pins;

   assign pins = {scl_i, sda_i};

   // First stage only feeds the second stage
   always_comb begin
      sync_d = sync_q;
      sync_d.s1 = pins;
      sync_d.s2 = sync_q.s1;
      sync_d.s3 = sync_q.s2;
   end

   // Lines idle high, so reset to high to avoid false edges
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sync_q <= '1;
      end else begin
         sync_q <= sync_d;
      end
   end

   // Edges: bit 1 is the clock line, bit 0 the data line
   assign scl_rise = sync_q.s2[1] & ~sync_q.s3[1];
   assign scl_fall = ~sync_q.s2[1] & sync_q.s3[1];
   // Data moving while clock stays high marks Start or Stop
   assign start_det = sync_q.s2[1] & sync_q.s3[1] & ~sync_q.s2[0] & sync_q.s3[0];
   assign stop_det = sync_q.s2[1] & sync_q.s3[1] & sync_q.s2[0] & ~sync_q.s3[0];
   assign sda_s = sync_q.s2[0];

endmodule

// ---- logic/dpr_target.sv ----
// Serial-bus target that holds two volatile wiper settings.
// Assumes open-drain bus lines pulled up outside; the bus clock is
// oversampled on clk_sys, which must run well above the bus rate.
module dpr_target (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Bus clock line, input only
   input wire logic scl_i,
   // Bus data line, open drain
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   // Wiper settings
   output logic [8:0] wiper0,
   output logic [8:0] wiper1
);

   // Complete state of the target
   typedef struct packed {
      dpr_pkg::dpr_state_t st;    // Interface state
      dpr_pkg::dpr_state_t after; // State after acknowledge slot
      logic [3:0] cnt;            // Bits seen in current byte
      logic [7:0] sh;             // Receive shift register
      logic gc;                   // Frame uses general call
      logic [3:0] ptr;            // Memory address pointer
      dpr_pkg::dpr_op_t op;       // Pending operation
      logic d8;                   // Top data bit from command
      logic apply;                // Operation runs at ack end
      logic rd_lo;                // Read is on low byte
      logic [1:0][8:0] wip;       // Wiper settings
      logic oe_n;                 // Low while pulling data low
   } dpr_target_t;

   dpr_target_t q, d;
   logic scl_rise, scl_fall, start_det, stop_det, sda_s;

   // Bus synchroniser and condition detection
   dpr_line_sync u_sync (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .start_det(start_det),
      .stop_det(stop_det),
      .sda_s(sda_s)
   );

   // Byte to send on a read: high byte carries only bit 8
   function automatic logic [7:0] rd_byte(input logic [8:0] w, input logic lo);
      rd_byte = lo ? w[7:0] : {7'h00, w[8]};
   endfunction

   // Saturating step of one wiper
   function automatic logic [8:0] step(input logic [8:0] w, input dpr_pkg::dpr_op_t op);
      // Reserved settings above full scale are left as they are
      step = w;
      if (op == dpr_pkg::DPR_OP_INC && w < dpr_pkg::DPR_WIPER_FULL) begin
         step = w + 9'h001;
      end else if (op == dpr_pkg::DPR_OP_DEC && w > dpr_pkg::DPR_WIPER_ZERO
                   && w <= dpr_pkg::DPR_WIPER_FULL) begin
         step = w - 9'h001;
      end
   endfunction

   // Next-state logic for the whole target
   always_comb begin
      logic [7:0] byte_in;
      logic valid;
      logic [7:0] rd_cur; // Byte being sent now
      logic [7:0] rd_nxt; // Byte sent after the master acks
      byte_in = {q.sh[6:0], sda_s};
      valid = 1'b0;
      // Read bytes kept as locals so that single bits can be picked
      rd_cur = rd_byte(q.wip[q.ptr[0]], q.rd_lo);
      rd_nxt = rd_byte(q.wip[q.ptr[0]], ~q.rd_lo);
      d = q;
      if (start_det) begin
         // Start always restarts the frame; wipers, pointer kept
         d.st = dpr_pkg::DPR_ST_ADDR;
         d.cnt = 4'h0;
         d.apply = 1'b0;
         d.oe_n = 1'b1;
      end else if (stop_det) begin
         // Stop returns to idle, nothing pending survives
         d.st = dpr_pkg::DPR_ST_IDLE;
         d.apply = 1'b0;
         d.oe_n = 1'b1;
      end else begin
         case (q.st)
            // Byte receive states share shifting and counting
            dpr_pkg::DPR_ST_ADDR, dpr_pkg::DPR_ST_CMD, dpr_pkg::DPR_ST_DATA: begin
               // Sample on the rising clock, finish the byte on the next fall
               if (scl_rise) begin
                  d.sh = byte_in;
                  d.cnt = q.cnt + 4'h1;
               end else if (scl_fall && q.cnt == dpr_pkg::DPR_BYTE_BITS) begin
                  d.st = dpr_pkg::DPR_ST_ACK;
                  d.cnt = 4'h0;
                  if (q.st == dpr_pkg::DPR_ST_ADDR) begin
                     // General call takes no reads
                     d.gc = (q.sh[7:1] == dpr_pkg::DPR_GC_ADDR);
                     valid = (q.sh[7:1] == dpr_pkg::DPR_DEV_ADDR) || (d.gc && !q.sh[0]);
                     d.after = q.sh[0] ? dpr_pkg::DPR_ST_RD : dpr_pkg::DPR_ST_CMD;
                     d.rd_lo = 1'b0;
                  end else if (q.st == dpr_pkg::DPR_ST_CMD) begin
                     d.ptr = q.sh[dpr_pkg::DPR_CMD_ADDR_LSB +: 4];
                     d.op = dpr_pkg::dpr_op_t'(q.sh[dpr_pkg::DPR_CMD_OP_LSB +: 2]);
                     d.d8 = q.sh[dpr_pkg::DPR_CMD_D8_POS];
                     // Only wiper addresses; reads not via general call
                     valid = (d.ptr <= dpr_pkg::DPR_PTR_MAX)
                             && !(q.gc && d.op == dpr_pkg::DPR_OP_READ);
                     d.apply = (d.op == dpr_pkg::DPR_OP_INC) || (d.op == dpr_pkg::DPR_OP_DEC);
                     d.after = (d.op == dpr_pkg::DPR_OP_WRITE) ? dpr_pkg::DPR_ST_DATA
                                                               : dpr_pkg::DPR_ST_CMD;
                  end else begin
                     // Data byte completes a write at the end of its ack
                     valid = 1'b1;
                     d.apply = 1'b1;
                     d.after = dpr_pkg::DPR_ST_CMD;
                  end
                  if (valid) begin
                     d.oe_n = 1'b0;
                  end else begin
                     // Unknown address or command: drop off the bus
                     d.st = dpr_pkg::DPR_ST_IGNORE;
                     d.apply = 1'b0;
                  end
               end
            end
            // Acknowledge slot; the update lands when it closes, so
            // a Stop during the slot cancels any pending write
            dpr_pkg::DPR_ST_ACK: begin
               if (scl_fall) begin
                  d.st = q.after;
                  d.oe_n = 1'b1;
                  d.apply = 1'b0;
                  if (q.apply) begin
                     if (q.op == dpr_pkg::DPR_OP_WRITE) begin
                        d.wip[q.ptr[0]] = {q.d8, q.sh};
                     end else begin
                        d.wip[q.ptr[0]] = step(q.wip[q.ptr[0]], q.op);
                     end
                  end
                  if (q.after == dpr_pkg::DPR_ST_RD) begin
                     // Present first read bit straight away; a one leaves
                     // the line released, a zero pulls it low
                     d.oe_n = rd_cur[7];
                  end
               end
            end
            // Shift out a read byte, one bit per clock low phase
            dpr_pkg::DPR_ST_RD: begin
               if (scl_rise) begin
                  d.cnt = q.cnt + 4'h1;
               end else if (scl_fall) begin
                  if (q.cnt == dpr_pkg::DPR_BYTE_BITS) begin
                     d.oe_n = 1'b1;
                     d.st = dpr_pkg::DPR_ST_RD_ACK;
                  end else begin
                     // Next bit, MSB first; cnt counts the rises already seen
                     d.oe_n = rd_cur[3'h7 - q.cnt[2:0]];
                  end
               end
            end
            // Master's slot: a released line means no more data
            dpr_pkg::DPR_ST_RD_ACK: begin
               if (scl_rise && sda_s) begin
                  d.st = dpr_pkg::DPR_ST_IGNORE;
               end else if (scl_fall) begin
                  d.st = dpr_pkg::DPR_ST_RD;
                  d.cnt = 4'h0;
                  // Master acked: alternate to the other byte of the wiper
                  d.rd_lo = ~q.rd_lo;
                  d.oe_n = rd_nxt[7];
               end
            end
            // Idle and ignore wait only for a Start
            dpr_pkg::DPR_ST_IDLE, dpr_pkg::DPR_ST_IGNORE: begin
               // Shift register and count are stale here; Start clears the count only
               d.oe_n = 1'b1;
            end
            default: begin
               // Unused encodings fall back to idle with the line released
               d.st = dpr_pkg::DPR_ST_IDLE;
               d.oe_n = 1'b1;
            end
         endcase
      end
   end

   // State register; power-on reset is the only wiper/pointer reset
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         q.st <= dpr_pkg::DPR_ST_IDLE;
         q.after <= dpr_pkg::DPR_ST_IDLE;
         q.cnt <= 4'h0;
         q.sh <= 8'h00;
         q.gc <= 1'b0;
         q.ptr <= dpr_pkg::DPR_PTR_RESET;
         q.op <= dpr_pkg::DPR_OP_WRITE;
         q.d8 <= 1'b0;
         q.apply <= 1'b0;
         q.rd_lo <= 1'b0;
         // Both wipers restart at mid-scale
         q.wip <= {dpr_pkg::DPR_WIPER_RESET, dpr_pkg::DPR_WIPER_RESET};
         q.oe_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   // Open drain: the pin is only ever pulled low, so the level is fixed
   assign sda_o = 1'b0;
   assign sda_oe_n = q.oe_n;
   assign wiper0 = q.wip[0];
   assign wiper1 = q.wip[1];

endmodule

// ---- bench/dpr_master_model.sv ----
// Bus master model for the wiper target.
// Assumes the bench resolves the open-drain data line with a pull-up.
module dpr_master_model (
   // Link clock
   input wire logic clk_link,
   // Bus lines
   output logic scl,
   output logic sda_m,
   input wire logic sda_bus
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int H = 8; // Half bit, above eight system cycles
   initial {scl, sda_m} = 2'h3; // Both lines released
   // Wait n link edges, then step off the edge
   task automatic hold(input int n);
      repeat (n) @(posedge clk_link);
      #1;
   endtask
   // One bit; r is the line level while the clock is high
   task automatic bit_io(input logic b, output logic r);
      sda_m = b;
      hold(H);
      scl = 1'b1;
      hold(H);
      r = sda_bus;
      scl = 1'b0;
      hold(3); // Data moves only once the fall is seen
   endtask
   // Start when s is high, Stop when low
   task automatic cond(input logic s);
      sda_m = s;
      hold(H);
      scl = 1'b1;
      hold(H);
      sda_m = ~s;
      hold(H);
      if (s) begin
         scl = 1'b0;
         hold(3);
      end
   endtask
   // Byte MSB first, then slot a; q is {byte, slot} as the line showed
   task automatic xfer(input logic [7:0] d, input logic a, output logic [8:0] q);
      logic r;
      for (int i = 8; i >= 0; i--) begin
         bit_io(i == 0 ? a : d[i - 1], r);
         q[i] = r;
      end
   endtask
   // Recovery: Start, nine released bits, Start, Stop
   task automatic recover();
      logic r;
      cond(1'b1);
      repeat (9) bit_io(1'b1, r);
      cond(1'b1);
      cond(1'b0);
   endtask
   // Named conditions, so callers need pass no levels
   task automatic send_start();
      cond(1'b1);
   endtask
   task automatic send_stop();
      cond(1'b0);
   endtask
   // One released bit whose sampled level is not wanted
   task automatic idle_bit();
      logic r;
      bit_io(1'b1, r);
   endtask
   // Give the target's synchroniser time to catch up
   task automatic settle();
      hold(3);
   endtask
endmodule

// ---- bench/dpr_target_monitor.sv ----
// Checker on the pins of the wiper target.
// Assumes raw bus pins; three flops mirror the target's synchroniser.
module dpr_target_monitor (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Bus lines
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n,
   // Wipers
   input wire logic [8:0] wiper0,
   input wire logic [8:0] wiper1
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] scl_q; // Delayed clock line
   logic [2:0] sda_q; // Delayed data line
   logic idle_q; // Set by Stop, cleared by Start
   logic start_w; // Start seen
   assign start_w = scl_q[1] & sda_q[2] & ~sda_q[1];
   // Condition tracking
   always_ff @(posedge clk_sys) begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
      if (!resetn || start_w) begin
         idle_q <= 1'b0;
      end else if (scl_q[1] & ~sda_q[2] & sda_q[1]) begin
         idle_q <= 1'b1;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   AST_OPEN_DRAIN: assert property (sda_o == 1'b0) else $error("drive value not zero");
   AST_RESET_STATE: assert property (disable iff (1'b0) !resetn |=> sda_oe_n && wiper0 == 9'h080
      && wiper1 == 9'h080) else $error("reset state wrong");
   AST_START_LISTEN: assert property (start_w |=> sda_oe_n [*8]) else $error("driven after Start");
   AST_IDLE_RELEASE: assert property (idle_q && $past(idle_q, 6) |-> sda_oe_n) else $error("driven idle");
   AST_IDLE_HOLD: assert property (idle_q && $past(idle_q, 6) |-> $stable(wiper0) && $stable(wiper1))
      else $error("wiper moved while idle");
   AST_DRIVE_CLK_LOW: assert property ($changed(sda_oe_n) |-> !scl_i) else $error("data moved, clock high");
   AST_WIPER_CLK_LOW: assert property ($changed(wiper0) || $changed(wiper1) |-> !scl_i)
      else $error("wiper moved, clock high");
endmodule

// ---- bench/dpr_target_tb.sv ----
// Self-checking bench for the wiper target.
// Assumes the master model and checker are compiled first.
module dpr_target_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'b0; // 100 MHz
   logic clk_link = 1'b0; // 12 ns, free phase
   logic resetn = 1'b0; // Active low
   logic scl, sda_m, sda_o, sda_oe_n; // Bus and target drive
   logic sda_bus; // Resolved data line
   logic [8:0] wiper0, wiper1; // Wipers
   int n_mismatch = 0;
   int n_checks = 0;
   always #5 clk_sys = ~clk_sys;
   initial begin
      #2.7;
      forever #6 clk_link = ~clk_link;
   end
   assign sda_bus = sda_m & (sda_oe_n | sda_o); // Pull-up: low if anyone pulls
   dpr_target dut (.clk_sys(clk_sys), .resetn(resetn), .scl_i(scl), .sda_i(sda_bus),
      .sda_o(sda_o), .sda_oe_n(sda_oe_n), .wiper0(wiper0), .wiper1(wiper1));
   dpr_master_model mst (.clk_link(clk_link), .scl(scl), .sda_m(sda_m), .sda_bus(sda_bus));
   // Exact four-state compare
   task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Write a byte; nak is the expected slot level
   task automatic wr(input logic [7:0] d, input logic nak, input string what);
      logic [8:0] q;
      mst.xfer(d, 1'b1, q);
      chk(q, {d, nak}, what);
   endtask
   // Read a byte; a high ends the read
   task automatic rd(input logic [7:0] e, input logic a, input string what);
      logic [8:0] q;
      mst.xfer(8'hFF, a, q);
      chk(q, {e, a}, what);
   endtask
   // Reset values, read from pointer zero
   task automatic t_reset();
      chk(wiper1, 9'h080, "wiper1 reset");
      mst.send_start();
      wr(8'h5D, 1'b0, "read addr");
      rd(8'h00, 1'b0, "high byte");
      rd(8'h80, 1'b1, "low byte");
      mst.send_stop();
   endtask
   // Broadcast write, capped increment, decrement; then own write
   task automatic t_update();
      mst.send_start();
      wr(8'h00, 1'b0, "bcast addr");
      wr(8'h01, 1'b0, "bcast write");
      wr(8'h00, 1'b0, "bcast data");
      wr(8'h04, 1'b0, "bcast inc");
      wr(8'h08, 1'b0, "bcast dec");
      mst.send_start();
      wr(8'h5C, 1'b0, "addr");
      wr(8'h11, 1'b0, "write cmd");
      wr(8'h55, 1'b0, "data");
      mst.send_stop();
      chk(wiper0, 9'h0FF, "wiper0");
      chk(wiper1, 9'h155, "wiper1");
   endtask
   // Pointer set, kept across Stop
   task automatic t_pointer();
      mst.send_start();
      wr(8'h5C, 1'b0, "addr");
      wr(8'h1C, 1'b0, "set pointer");
      mst.send_stop();
      mst.send_start();
      wr(8'h5D, 1'b0, "read addr");
      rd(8'h01, 1'b0, "high byte");
      rd(8'h55, 1'b1, "low byte");
      mst.send_stop();
   endtask
   // Idle after Stop; refused commands ignored until Start
   task automatic t_refuse();
      mst.send_start();
      wr(8'h5C, 1'b0, "addr");
      mst.send_stop();
      mst.idle_bit();
      wr(8'h11, 1'b1, "cmd, no Start");
      mst.send_start();
      wr(8'h5C, 1'b0, "addr");
      wr(8'h21, 1'b1, "bad cmd");
      wr(8'h11, 1'b1, "ignored cmd");
      mst.send_start();
      wr(8'h01, 1'b1, "bcast read");
      mst.send_stop();
      chk(wiper1, 9'h155, "wiper1 kept");
   endtask
   // Recovery from a read stalled on a zero bit
   task automatic t_recover();
      mst.send_start();
      wr(8'h5C, 1'b0, "addr");
      wr(8'h1C, 1'b0, "set pointer");
      mst.send_start();
      wr(8'h5D, 1'b0, "read addr");
      mst.idle_bit();
      mst.idle_bit();
      mst.settle();
      chk({8'h00, sda_bus}, 9'h000, "zero held");
      mst.recover();
      chk({8'h00, sda_oe_n}, 9'h001, "released");
      chk(wiper1, 9'h155, "wiper1 kept");
      mst.send_start();
      wr(8'h5C, 1'b0, "addr");
      wr(8'h04, 1'b0, "inc");
      mst.send_stop();
      chk(wiper0, 9'h100, "wiper0 inc");
   endtask
   initial begin
      repeat (12) @(posedge clk_sys);
      #1 resetn = 1'b1;
      repeat (4) @(posedge clk_sys);
      t_reset();
      t_update();
      t_pointer();
      t_refuse();
      t_recover();
      report_and_stop();
   end
   // Hang guard
   initial begin
      repeat (100000) @(posedge clk_sys);
      n_mismatch++;
      report_and_stop();
   end
endmodule
bind dpr_target dpr_target_monitor mon (.clk_sys(clk_sys), .resetn(resetn), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_n(sda_oe_n), .wiper0(wiper0), .wiper1(wiper1));
